// file: include/wdt_map.vh
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_RST_CAUSE 16'h0054
`define IO_ADDR_RST_CAUSE 16'h0034
`define ADDR_WDT_CTRL 16'h0060
`define IO_SPACE_OFFSET 16'h0020
`define IO_ADDR_MAX 16'h003f

// ----------------------------------------
// Reset cause field positions
// ----------------------------------------
`define RC_POWER_ON 0
`define RC_EXT_PIN 1
`define RC_BROWNOUT 2
`define RC_WATCHDOG 3
`define RC_DEBUG_PORT 4

// ----------------------------------------
// Watchdog control field positions
// ----------------------------------------
`define WC_PERIOD_LO 0
`define WC_RESET_EN 3
`define WC_UNLOCK 4
`define WC_PERIOD_HI 5
`define WC_IRQ_EN 6
`define WC_IRQ_FLAG 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CAUSE_RESET 8'h00
`define WDT_CTRL_RESET 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define SYS_CLK_HZ 20000000
`define WDT_OSC_HZ 128000
`define OSC_DIV_CYCLES (`SYS_CLK_HZ / `WDT_OSC_HZ)
`define UNLOCK_CYCLES 3'h4
`define BASE_PERIOD_TICKS 2048
`define PERIOD_SEL_MAX 4'h9

`endif

// file: rtl/wdt_tick_counter.v
`include "wdt_map.vh"

module wdt_tick_counter #(
    parameter BASE_TICKS = `BASE_PERIOD_TICKS
) (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_nrst,
    // Control
    input wire i_run,
    input wire i_restart,
    input wire [3:0] i_period_sel,
    // Event
    output reg o_expire
);

    // ----------------------------------------
    // Oscillator tick enable
    // ----------------------------------------
    // 20 MHz does not divide evenly to the oscillator rate; rounding down
    // makes the watchdog run slightly fast, never late.
    localparam integer DIV_LAST_FULL = (`OSC_DIV_CYCLES) - 1;
    localparam [7:0] DIV_LAST = DIV_LAST_FULL[7:0];
    reg [7:0] div_q;
    wire tick;

    assign tick = (div_q == DIV_LAST);

    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            div_q <= 8'h00;
        end else if (tick) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // ----------------------------------------
    // Period count
    // ----------------------------------------
    reg [3:0] sel;
    reg [20:0] cnt_q;
    wire [20:0] limit;

    always @* begin
        sel = i_period_sel;
        if (sel > `PERIOD_SEL_MAX) begin
            sel = `PERIOD_SEL_MAX;
        end
    end

    assign limit = BASE_TICKS[20:0] << sel;

    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= 21'h000000;
            o_expire <= 1'b0;
        end else begin
            o_expire <= 1'b0;
            if (i_restart || !i_run) begin
                cnt_q <= 21'h000000;
            end else if (tick) begin
                // Compare at or above, so a shorter period takes effect at once
                if (cnt_q + 21'h000001 >= limit) begin
                    cnt_q <= 21'h000000;
                    o_expire <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 21'h000001;
                end
            end
        end
    end

endmodule // wdt_tick_counter

// file: rtl/wdt_reset_cause.v
`include "wdt_map.vh"

//
// Contract
// - Reset cause register at data 0x54, I/O 0x34, five low flags, resets to 0x01 (power-on flag set).
// - Short I/O address equals data offset minus 0x20, range 0x00 to 0x3F.
// - Extended space from 0x60 reachable only by data-space accesses.
// - Debug-port reset flag set by test-port reset register logic one.
// - Watchdog reset flag set on every watchdog system reset.
// - Brown-out reset flag set on every brown-out reset.
// - External pin reset flag set on every external reset.
// - Power-on clears four non-power flags; writing zero also clears each.
// - Power-on flag set by power-on, cleared only by writing zero.
// - Watchdog control at data 0x60, reset 0x00, fixed bit layout.
// - Interrupt flag set on time-out when interrupt action configured.
// - Interrupt flag cleared by vector execution or writing one.
// - Interrupt request needs flag, enable and global interrupt enable.
// - Fuse unprogrammed: reset/irq enables select stop, irq, reset, combined.
// - Combined mode vector clears enable and flag; second time-out resets.
// - Fuse programmed: always reset mode, enables ignored.
// - Clearing reset enable or period change needs unlock; unlock lasts four cycles.
// - Reset enable reads and acts set while watchdog reset flag set.
// - Period code selects 2048 doubling to 1048576 oscillator cycles.
// - Counter counts 128 kHz oscillator ticks independent of system clock; here ticks come from dividing the system clock by 156.
// - Reset mode time-out gives a one system clock reset pulse.
// - Fuse programmed holds reset enable one and interrupt enable zero.
//
module wdt_reset_cause #(
    parameter BASE_TICKS = `BASE_PERIOD_TICKS
) (
    // Clock and power-on reset
    input wire i_clk_sys,
    input wire i_nrst,
    // CPU register access
    input wire [15:0] i_addr,
    input wire i_io_space,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata,
    // CPU events
    input wire i_wdt_restart,
    input wire i_wdt_vector_taken,
    input wire i_global_irq_enable,
    // Reset sources and fuse
    input wire i_ext_pin_reset,
    input wire i_brownout_reset,
    input wire i_debug_port_reset,
    input wire i_always_on_fuse_n,
    // Watchdog outputs
    output reg o_wdt_irq_req,
    output reg o_wdt_sys_reset
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    reg [15:0] eff_addr;
    reg addr_ok;
    wire hit_cause;
    wire hit_ctrl;
    wire wr_cause;
    wire wr_ctrl;

    always @* begin
        eff_addr = i_addr;
        addr_ok = 1'b1;
        if (i_io_space) begin
            // Short form only covers 64 locations below the extended space
            addr_ok = (i_addr <= `IO_ADDR_MAX);
            eff_addr = i_addr + `IO_SPACE_OFFSET;
        end
    end

    assign hit_cause = addr_ok && (eff_addr == `ADDR_RST_CAUSE);
    assign hit_ctrl = addr_ok && (eff_addr == `ADDR_WDT_CTRL);
    assign wr_cause = i_wr && hit_cause;
    assign wr_ctrl = i_wr && hit_ctrl;

    // ----------------------------------------
    // Fuse and effective mode
    // ----------------------------------------
    wire fuse_prog;
    reg wde_q;
    reg watchdog_irq_enable_q;
    reg watchdog_irq_flag_q;
    reg [3:0] wdp_q;
    reg [2:0] unlock_q;
    reg [4:0] cause_q;
    wire wde_eff;
    wire watchdog_irq_enable_eff;
    wire unlocked;
    wire run;

    assign fuse_prog = ~i_always_on_fuse_n;
    assign unlocked = (unlock_q != 3'h0);
    assign wde_eff = wde_q | cause_q[`RC_WATCHDOG] | fuse_prog;
    assign watchdog_irq_enable_eff = watchdog_irq_enable_q & ~fuse_prog;
    assign run = wde_eff | watchdog_irq_enable_eff;

    // ----------------------------------------
    // Watchdog counter
    // ----------------------------------------
    wire expire;
    wire any_reset;
    reg fire;

    assign any_reset = i_ext_pin_reset | i_brownout_reset | i_debug_port_reset;

    wdt_tick_counter #(
        .BASE_TICKS(BASE_TICKS)
    ) u_counter (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_run(run),
        .i_restart(i_wdt_restart | fire | any_reset),
        .i_period_sel(wdp_q),
        .o_expire(expire)
    );

    // ----------------------------------------
    // Time-out action
    // ----------------------------------------
    reg set_irq;

    always @* begin
        set_irq = 1'b0;
        fire = 1'b0;
        if (expire) begin
            if (watchdog_irq_enable_eff && !wde_eff) begin
                set_irq = 1'b1;
            end else if (wde_eff && !watchdog_irq_enable_eff) begin
                fire = 1'b1;
            end else if (wde_eff && watchdog_irq_enable_eff) begin
                // Flag still pending means the handler never ran
                if (watchdog_irq_flag_q) begin
                    fire = 1'b1;
                end else begin
                    set_irq = 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Reset cause flags
    // ----------------------------------------
    reg [4:0] cause_d;

    always @* begin
        cause_d = cause_q;
        if (wr_cause) begin
            cause_d = cause_q & i_wdata[4:0];
        end
        // Set wins over a clearing write in the same cycle
        if (i_debug_port_reset) begin
            cause_d[`RC_DEBUG_PORT] = 1'b1;
        end
        if (fire) begin
            cause_d[`RC_WATCHDOG] = 1'b1;
        end
        if (i_brownout_reset) begin
            cause_d[`RC_BROWNOUT] = 1'b1;
        end
        if (i_ext_pin_reset) begin
            cause_d[`RC_EXT_PIN] = 1'b1;
        end
    end

    // Power-on clears the four event flags and sets the power-on flag
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cause_q <= 5'h01;
        end else begin
            cause_q <= cause_d;
        end
    end

    // ----------------------------------------
    // Watchdog control register
    // ----------------------------------------
    reg wde_d;
    reg watchdog_irq_enable_d;
    reg watchdog_irq_flag_d;
    reg [3:0] wdp_d;
    reg [2:0] unlock_d;
    localparam [7:0] CTRL_RESET = `WDT_CTRL_RESET;

    always @* begin
        wde_d = wde_q;
        watchdog_irq_enable_d = watchdog_irq_enable_q;
        watchdog_irq_flag_d = watchdog_irq_flag_q;
        wdp_d = wdp_q;
        unlock_d = unlocked ? unlock_q - 3'h1 : 3'h0;
        if (wr_ctrl) begin
            watchdog_irq_enable_d = i_wdata[`WC_IRQ_EN];
            if (i_wdata[`WC_IRQ_FLAG]) begin
                watchdog_irq_flag_d = 1'b0;
            end
            if (i_wdata[`WC_UNLOCK]) begin
                // Opening write only sets the reset enable, never changes period
                unlock_d = `UNLOCK_CYCLES;
                wde_d = wde_q | i_wdata[`WC_RESET_EN];
            end else if (unlocked) begin
                wde_d = i_wdata[`WC_RESET_EN];
                wdp_d = {i_wdata[`WC_PERIOD_HI], i_wdata[2:0]};
                unlock_d = 3'h0;
            end else begin
                wde_d = wde_q | i_wdata[`WC_RESET_EN];
            end
        end
        if (i_wdt_vector_taken) begin
            watchdog_irq_flag_d = 1'b0;
            if (wde_eff && watchdog_irq_enable_eff) begin
                watchdog_irq_enable_d = 1'b0;
            end
        end
        if (set_irq) begin
            watchdog_irq_flag_d = 1'b1;
        end
        if (cause_q[`RC_WATCHDOG]) begin
            wde_d = 1'b1;
        end
        // Any system reset returns the control register to its reset value
        if (fire || any_reset) begin
            wde_d = CTRL_RESET[`WC_RESET_EN];
            watchdog_irq_enable_d = CTRL_RESET[`WC_IRQ_EN];
            watchdog_irq_flag_d = CTRL_RESET[`WC_IRQ_FLAG];
            wdp_d = {CTRL_RESET[`WC_PERIOD_HI], CTRL_RESET[2:0]};
            unlock_d = 3'h0;
        end
    end

    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            wde_q <= 1'b0;
            watchdog_irq_enable_q <= 1'b0;
            watchdog_irq_flag_q <= 1'b0;
            wdp_q <= 4'h0;
            unlock_q <= 3'h0;
        end else begin
            wde_q <= wde_d;
            watchdog_irq_enable_q <= watchdog_irq_enable_d;
            watchdog_irq_flag_q <= watchdog_irq_flag_d;
            wdp_q <= wdp_d;
            unlock_q <= unlock_d;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    reg [7:0] rd_d;

    always @* begin
        rd_d = 8'h00;
        if (hit_cause) begin
            rd_d = {3'h0, cause_q};
        end else if (hit_ctrl) begin
            rd_d = {watchdog_irq_flag_q, watchdog_irq_enable_eff, wdp_q[3], unlocked, wde_eff, wdp_q[2:0]};
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 8'h00;
            o_wdt_irq_req <= 1'b0;
            o_wdt_sys_reset <= 1'b0;
        end else begin
            o_rdata <= i_rd ? rd_d : 8'h00;
            o_wdt_irq_req <= watchdog_irq_flag_q & watchdog_irq_enable_eff & i_global_irq_enable;
            o_wdt_sys_reset <= fire;
        end
    end

endmodule // wdt_reset_cause

// file: tb/wdt_reset_cause_checker.sv
module wdt_reset_cause_checker #(
    parameter BASE_TICKS = 2048
) (
    // Clock, reset and bus
    input wire i_clk_sys,
    input wire i_nrst,
    input wire [15:0] i_addr,
    input wire i_io_space,
    input wire i_rd,
    input wire [7:0] o_rdata,
    // Events and outputs
    input wire i_wdt_restart,
    input wire i_wdt_vector_taken,
    input wire i_global_irq_enable,
    input wire i_ext_pin_reset,
    input wire i_brownout_reset,
    input wire i_debug_port_reset,
    input wire i_always_on_fuse_n,
    input wire o_wdt_irq_req,
    input wire o_wdt_sys_reset
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Cycles since the counter last restarted
    // ----------------------------------------
    int run_q;
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) run_q <= 0;
        else if (i_wdt_restart | i_ext_pin_reset | i_brownout_reset | i_debug_port_reset | o_wdt_sys_reset) run_q <= 0;
        else if (run_q < 2000000) run_q <= run_q + 1;
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    reset_pulse_a: assert property (o_wdt_sys_reset |=> !o_wdt_sys_reset) else $error("reset pulse too long");
    irq_gate_a: assert property (o_wdt_irq_req |-> $past(i_global_irq_enable)) else $error("irq without gie");
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata not idle");
    cause_bits_a: assert property ($past(i_rd && !i_io_space && i_addr == 16'h0054) |-> o_rdata[7:5] == 3'h0)
        else $error("cause upper bits set");
    ext_space_a: assert property ($past(i_rd && i_io_space && i_addr == 16'h0040) |-> o_rdata == 8'h00)
        else $error("extended reg via io");
    fuse_noirq_a: assert property (!$past(i_always_on_fuse_n) |-> !o_wdt_irq_req) else $error("irq with fuse");
    min_period_a: assert property (o_wdt_sys_reset |-> run_q >= 156 * (BASE_TICKS - 1))
        else $error("timeout too early");
    vector_clear_a: assert property (i_wdt_vector_taken |-> ##2 !o_wdt_irq_req) else $error("flag kept");
    fuse_read_a: assert property ($past(i_rd && !i_io_space && i_addr == 16'h0060 && !i_always_on_fuse_n)
        |-> o_rdata[3] && !o_rdata[6]) else $error("fuse bits wrong");
    // Main scenarios reached
    cover property (o_wdt_sys_reset);
    cover property (o_wdt_irq_req);
    cover property (i_wdt_vector_taken && o_wdt_irq_req);
    cover property (i_rd && i_io_space);
endmodule // wdt_reset_cause_checker

bind wdt_reset_cause wdt_reset_cause_checker #(.BASE_TICKS(BASE_TICKS)) i_wdt_reset_cause_checker (.i_clk_sys,
    .i_nrst, .i_addr, .i_io_space, .i_rd, .o_rdata, .i_wdt_restart, .i_wdt_vector_taken, .i_global_irq_enable,
    .i_ext_pin_reset, .i_brownout_reset, .i_debug_port_reset, .i_always_on_fuse_n, .o_wdt_irq_req,
    .o_wdt_sys_reset);

// file: tb/cpu_model.sv
module cpu_model (
    // Clock and read data
    input wire logic i_clk_sys,
    input wire logic [7:0] i_rdata,
    // Register access
    output logic [15:0] o_addr,
    output logic o_io,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_addr = 16'h0000;
        o_io = 1'b0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
    end
    // One strobe edge; read data stands one cycle, taken at the edge after
    task automatic acc(input logic w, input logic io, input logic [15:0] a, input logic [7:0] d,
        output logic [7:0] q);
        o_addr <= a;
        o_io <= io;
        o_wdata <= d;
        o_wr <= w;
        o_rd <= !w;
        @(posedge i_clk_sys);
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        @(posedge i_clk_sys);
        q = i_rdata;
    endtask
    // Timed sequence: second write lands two cycles after the first
    task automatic unlock_wr(input logic [7:0] v);
        logic [7:0] q;
        acc(1'b1, 1'b0, 16'h0060, 8'h18, q);
        acc(1'b1, 1'b0, 16'h0060, v, q);
    endtask
endmodule // cpu_model

// file: tb/watchdog_and_reset_cause_flags_tb_top.sv
module watchdog_and_reset_cause_flags_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, nrst = 1'b0, restart = 1'b0, vec = 1'b0, gie = 1'b0, fuse_n = 1'b1;
    logic [2:0] evt = 3'h0;
    logic [15:0] addr;
    logic io, wr, rd, irq, sysrst;
    logic [7:0] wdata, rdata, q, d;
    logic [7:0] m_rc = 8'h01, m_ctl = 8'h00;
    int fails = 0, n_compared = 0;
    always #25 clk = ~clk;
    wdt_reset_cause #(.BASE_TICKS(4)) i_wdt_reset_cause (.i_clk_sys(clk), .i_nrst(nrst), .i_addr(addr),
        .i_io_space(io), .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata), .i_wdt_restart(restart),
        .i_wdt_vector_taken(vec), .i_global_irq_enable(gie), .i_ext_pin_reset(evt[0]),
        .i_brownout_reset(evt[1]), .i_debug_port_reset(evt[2]), .i_always_on_fuse_n(fuse_n),
        .o_wdt_irq_req(irq), .o_wdt_sys_reset(sysrst));
    cpu_model i_cpu_model (.i_clk_sys(clk), .i_rdata(rdata), .o_addr(addr), .o_io(io), .o_wr(wr), .o_rd(rd),
        .o_wdata(wdata));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask
    task automatic rdc(input logic i, input logic [15:0] a, input logic [7:0] e);
        logic [7:0] r;
        i_cpu_model.acc(1'b0, i, a, 8'h00, r);
        chk(r, e);
    endtask
    // Control as read: reset flag and fuse override the stored bits
    function automatic logic [7:0] ectl();
        logic [7:0] e;
        e = m_ctl | {4'h0, m_rc[3], 3'h0};
        if (!fuse_n) e = (e & 8'hbf) | 8'h08;
        return e;
    endfunction
    task automatic cw(input logic [7:0] v, input logic ul);
        if (ul) i_cpu_model.unlock_wr(v);
        else i_cpu_model.acc(1'b1, 1'b0, 16'h0060, v, q);
        m_ctl[7] = m_ctl[7] & !v[7];
        m_ctl[6] = v[6];
        m_ctl[3] = ul ? v[3] : (m_ctl[3] | v[3]);
        if (ul) {m_ctl[5], m_ctl[2:0]} = {v[5], v[2:0]};
    endtask
    task automatic wrc(input logic [7:0] v);
        i_cpu_model.acc(1'b1, 1'b0, 16'h0054, v, q);
        m_rc = m_rc & v;
    endtask
    task automatic ev(input int k);
        evt <= 3'h1 << k;
        @(posedge clk);
        evt <= 3'h0;
        @(posedge clk);
        m_rc = m_rc | ((k == 2) ? 8'h10 : 8'h02 << k);
        m_ctl = 8'h00;
    endtask
    task automatic rs();
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
    endtask
    task automatic vect();
        vec <= 1'b1;
        @(posedge clk);
        vec <= 1'b0;
        @(posedge clk);
        m_ctl[7] = 1'b0;
        if (m_ctl[3]) m_ctl[6] = 1'b0;
    endtask
    // Wait bounded by the selected period; oscillator phase allows one tick early
    task automatic tmo(input logic want_irq);
        int n, t;
        t = 156 * (4 << {m_ctl[5], m_ctl[2:0]});
        n = 0;
        while ((want_irq ? irq : sysrst) !== 1'b1 && n < t + 200) begin
            @(posedge clk);
            n++;
        end
        chk(8'(n >= t - 160 && n <= t + 8), 8'h01);
        if (want_irq) m_ctl[7] = 1'b1;
        else m_rc[3] = 1'b1;
        if (!want_irq) m_ctl = 8'h00;
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #2000000;
        fails++;
        end_sim();
    end
    initial begin
        void'($urandom(17));
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rdc(1'b0, 16'h0054, m_rc);
        rdc(1'b1, 16'h0034, m_rc);
        rdc(1'b0, 16'h0060, ectl());
        rdc(1'b1, 16'h0040, 8'h00);
        rdc(1'b0, 16'h0100 + 16'($urandom % 256), 8'h00);
        for (int k = 0; k < 3; k++) begin
            ev(k);
            rdc(1'b0, 16'h0054, m_rc);
        end
        d = 8'($urandom);
        wrc(d);
        rdc(1'b0, 16'h0054, m_rc);
        wrc(8'h00);
        rdc(1'b1, 16'h0034, m_rc);
        rs();
        cw(8'h08, 1'b0);
        cw(8'h00, 1'b0);
        rdc(1'b0, 16'h0060, ectl());
        cw(8'h18, 1'b0);
        rdc(1'b0, 16'h0060, ectl() | 8'h10);
        repeat (3) @(posedge clk);
        cw(8'h00, 1'b0);
        rdc(1'b0, 16'h0060, ectl());
        cw(8'h40 | 8'($urandom % 2), 1'b1);
        rdc(1'b0, 16'h0060, ectl());
        gie <= 1'b1;
        rs();
        tmo(1'b1);
        rdc(1'b0, 16'h0060, ectl());
        gie <= 1'b0;
        repeat (2) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        gie <= 1'b1;
        repeat (2) @(posedge clk);
        chk({7'h00, irq}, 8'h01);
        cw(8'hc0, 1'b0);
        rdc(1'b0, 16'h0060, ectl());
        // Restarts spaced below the shortest period must keep the flag clear
        repeat (5) begin
            repeat (300) @(posedge clk);
            rs();
        end
        rdc(1'b0, 16'h0060, ectl());
        rs();
        tmo(1'b1);
        vect();
        rdc(1'b0, 16'h0060, ectl());
        cw(8'h48, 1'b0);
        rs();
        tmo(1'b1);
        vect();
        rdc(1'b0, 16'h0060, ectl());
        rs();
        tmo(1'b0);
        rdc(1'b0, 16'h0054, m_rc);
        cw(8'h48, 1'b0);
        rs();
        tmo(1'b1);
        tmo(1'b0);
        rdc(1'b0, 16'h0054, m_rc);
        rdc(1'b0, 16'h0060, ectl());
        cw(8'h00, 1'b1);
        rdc(1'b0, 16'h0060, ectl());
        wrc(8'h00);
        cw(8'h00, 1'b1);
        rdc(1'b0, 16'h0060, ectl());
        // Stopped mode: no reset may be flagged over more than one period
        repeat (700) @(posedge clk);
        rdc(1'b0, 16'h0054, m_rc);
        fuse_n <= 1'b0;
        @(posedge clk);
        cw(8'h40, 1'b0);
        rdc(1'b0, 16'h0060, ectl());
        rs();
        tmo(1'b0);
        rdc(1'b0, 16'h0054, m_rc);
        fuse_n <= 1'b1;
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        m_rc = 8'h01;
        m_ctl = 8'h00;
        rdc(1'b0, 16'h0054, m_rc);
        rdc(1'b0, 16'h0060, ectl());
        end_sim();
    end
endmodule // watchdog_and_reset_cause_flags_tb_top
